/* hw/brx_pkg.sv */
package brx_pkg;
    localparam int DATA_LINES = 10;
    localparam int ERR_BITS = 7;
    localparam int ERR_LINE_LO = 2;
    // error bit index inside the latch; bus line is index plus ERR_LINE_LO
    localparam int EB_OVERFLOW = 0;
    localparam int EB_PARITY = 1;
    localparam int EB_TX_CHECK = 2;
    localparam int EB_BAD_END = 3;
    localparam int EB_LOST_MID = 4;
    localparam int EB_RESTART = 5;
    localparam int EB_DISABLED = 6;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_ERRCODE = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    // interrupt status bits
    localparam int IRQ_BITS = 3;
    localparam int IB_ERROR = 0;
    localparam int IB_BYTE = 1;
    localparam int IB_MSG_END = 2;
    localparam logic [IRQ_BITS-1:0] MASK_RESET = 3'h0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int ERRCODE_FLAG_BIT = 8;
    localparam int ERRCODE_ACTIVE_BIT = 9;
    localparam int ERRCODE_WAIT_BIT = 10;

    typedef struct packed {
        logic out_sel;   // 1 data, 0 error code
        logic bus_en;    // 1 drive bus
        logic rd_n;      // read strobe, low while reading
    } brx_host_in_t;

    typedef struct packed {
        logic [DATA_LINES-1:0] data;
        logic [DATA_LINES-1:0] oe_n;
    } brx_host_out_t;

    typedef struct packed {
        logic start_seq;
        logic end_ok;
        logic end_bad;
        logic parity_err;
        logic lost_midbit;
        logic rx_disable;
        logic byte_valid;
        logic [DATA_LINES-1:0] byte_data;
    } brx_rx_ev_t;
endpackage

/* hw/brx_err_latch.sv */
`timescale 1ns/1ns
module brx_err_latch #(
    parameter int N = 7
) (
    input wire logic hclk,       // clock
    input wire logic hresetn,    // async reset, active low
    input wire logic [N-1:0] set, // error events
    input wire logic clr,        // clear all bits
    output logic [N-1:0] bits    // latched error bits
);
    import brx_pkg::*;
    typedef struct packed {
        logic [N-1:0] bits;
    } brx_el_state_t;
    brx_el_state_t s_reg, s_next;

    initial begin
        if (N < 1) $error("brx_err_latch: N must be at least 1");
    end

    always_comb begin
        s_next = s_reg;
        // set beats clear so an error in the clearing cycle survives
        s_next.bits = (s_reg.bits & ~{N{clr}}) | set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bits = s_reg.bits;
endmodule // brx_err_latch

/* hw/brx_ahb_slave.sv */
`timescale 1ns/1ns
module brx_ahb_slave (
    input wire logic hclk,          // clock
    input wire logic hresetn,       // async reset, active low
    input wire logic hsel,          // slave select
    input wire logic [7:0] haddr,   // byte address
    input wire logic [1:0] htrans,  // transfer type
    input wire logic hwrite,        // write
    input wire logic [2:0] hsize,   // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready,        // bus ready
    output logic hreadyout,         // always ready
    output logic [31:0] hrdata,     // read data
    output logic hresp,             // always OKAY
    output logic [7:0] rd_addr,     // read address, address phase
    input wire logic [31:0] rd_data,// read value for rd_addr
    output logic wr_en,             // write strobe, data phase
    output logic [7:0] wr_addr,     // write address
    output logic [31:0] wr_data     // write data
);
    import brx_pkg::*;
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } brx_ahb_state_t;
    brx_ahb_state_t s_reg, s_next;
    logic take;

    // only word transfers are decoded; other sizes still complete OKAY
    assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

    always_comb begin
        s_next = s_reg;
        s_next.wr_pend = take && hwrite;
        if (take && hwrite) begin
            s_next.wr_addr = haddr;
        end
        // read value sampled at the address phase edge
        if (take && !hwrite) begin
            s_next.rdata = rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign rd_addr = haddr;
    assign wr_en = s_reg.wr_pend;
    assign wr_addr = s_reg.wr_addr;
    assign wr_data = hwdata;
endmodule // brx_ahb_slave

/* hw/brx_port.sv */
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module brx_port #(
    parameter int DATA_W = 10
) (
    input wire logic hclk,                    // receiver clock, 8x bit rate
    input wire logic hresetn,                 // async reset, active low
    input wire logic hsel,                    // ahb select
    input wire logic [7:0] haddr,             // ahb address
    input wire logic [1:0] htrans,            // ahb transfer type
    input wire logic hwrite,                  // ahb write
    input wire logic [2:0] hsize,             // ahb size
    input wire logic [31:0] hwdata,           // ahb write data
    input wire logic hready,                  // ahb ready in
    output logic hreadyout,                   // ahb ready out
    output logic [31:0] hrdata,               // ahb read data
    output logic hresp,                       // ahb response
    input wire brx_pkg::brx_host_in_t host_in,   // host port controls
    output brx_pkg::brx_host_out_t host_out,     // host port bus
    input wire brx_pkg::brx_rx_ev_t rx_ev,       // receiver path events
    output logic err_flag,                    // any error latched
    output logic msg_active,                  // message in progress
    output logic byte_waiting,                // holding register full
    output logic irq                          // level interrupt
);
    import brx_pkg::*;

    typedef struct packed {
        logic [DATA_LINES-1:0] hold_data;
        logic [DATA_LINES-1:0] pend_data;
        logic hold_full;
        logic pend_full;
        logic msg_active;
        logic rd_n_d;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] mask;
        logic ctrl_en;
    } brx_state_t;

    brx_state_t s_reg, s_next;
    logic [ERR_BITS-1:0] err_set, err_bits;
    logic err_clr, rd_rise, start_ok, ovf, any_err;
    logic [7:0] rd_addr, wr_addr;
    logic [31:0] rd_data, wr_data;
    logic wr_en;
    logic [IRQ_BITS-1:0] irq_ev;
    logic [DATA_LINES-1:0] err_lines;

    initial begin
        if (DATA_W != DATA_LINES) $error("brx_port: DATA_W must equal DATA_LINES");
    end

    brx_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    brx_err_latch #(.N(ERR_BITS)) u_err (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(err_set),
        .clr(err_clr),
        .bits(err_bits)
    );

    assign rd_rise = host_in.rd_n && !s_reg.rd_n_d;
    assign start_ok = rx_ev.start_seq && s_reg.ctrl_en;
    // error read completes on strobe release with error code selected
    assign err_clr = (rd_rise && !host_in.out_sel) || start_ok;

    always_comb begin
        s_next = s_reg;
        err_set = '0;
        ovf = 1'b0;
        s_next.rd_n_d = host_in.rd_n;

        // data read done: free holding register on strobe release
        if (rd_rise && host_in.out_sel) begin
            s_next.hold_full = 1'b0;
        end
        // pending byte moves only while strobe is high; one cycle gap first
        if (!s_reg.hold_full && s_reg.pend_full && host_in.rd_n) begin
            s_next.hold_data = s_reg.pend_data;
            s_next.hold_full = 1'b1;
            s_next.pend_full = 1'b0;
        end

        if (start_ok) begin
            s_next.msg_active = 1'b1;
            err_set[EB_RESTART] = s_reg.hold_full;
        end
        if (rx_ev.end_ok && s_reg.msg_active) begin
            s_next.msg_active = 1'b0;
        end

        if (rx_ev.byte_valid && s_reg.msg_active) begin
            if (s_next.pend_full) begin
                ovf = 1'b1;
            // a holding register freed at this edge still takes its byte via pending,
            // so byte_waiting stays low one full cycle between bytes
            end else if (!s_reg.hold_full && !s_next.hold_full && host_in.rd_n) begin
                s_next.hold_data = rx_ev.byte_data;
                s_next.hold_full = 1'b1;
            end else begin
                s_next.pend_data = rx_ev.byte_data;
                s_next.pend_full = 1'b1;
            end
        end

        err_set[EB_OVERFLOW] = ovf;
        err_set[EB_PARITY] = rx_ev.parity_err && s_reg.msg_active;
        err_set[EB_BAD_END] = rx_ev.end_bad && s_reg.msg_active;
        err_set[EB_LOST_MID] = rx_ev.lost_midbit && s_reg.msg_active;
        err_set[EB_DISABLED] = rx_ev.rx_disable && s_reg.msg_active;
        err_set[EB_TX_CHECK] = err_set[EB_PARITY] || err_set[EB_BAD_END]
            || err_set[EB_LOST_MID];
        any_err = |err_set;

        if (any_err) begin
            s_next.msg_active = 1'b0;
            s_next.hold_full = 1'b0;
            s_next.pend_full = 1'b0;
        end

        irq_ev = '0;
        irq_ev[IB_ERROR] = any_err;
        irq_ev[IB_BYTE] = s_next.hold_full && !s_reg.hold_full;
        irq_ev[IB_MSG_END] = rx_ev.end_ok && s_reg.msg_active && !any_err;

        if (wr_en && wr_addr == OFS_STATUS) begin
            s_next.status = s_reg.status & ~wr_data[IRQ_BITS-1:0];
        end else if (wr_en && wr_addr == OFS_MASK) begin
            s_next.mask = wr_data[IRQ_BITS-1:0];
        end else if (wr_en && wr_addr == OFS_CTRL) begin
            s_next.ctrl_en = wr_data[0];
        end
        // new events win over a write-one clear in the same cycle
        s_next.status = s_next.status | irq_ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.rd_n_d <= 1'b1;
            s_reg.mask <= MASK_RESET;
            s_reg.ctrl_en <= CTRL_EN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        rd_data = '0;
        if (rd_addr == OFS_STATUS) begin
            rd_data[IRQ_BITS-1:0] = s_reg.status;
        end else if (rd_addr == OFS_MASK) begin
            rd_data[IRQ_BITS-1:0] = s_reg.mask;
        end else if (rd_addr == OFS_CTRL) begin
            rd_data[0] = s_reg.ctrl_en;
        end else if (rd_addr == OFS_ERRCODE) begin
            rd_data[ERR_BITS-1:0] = err_bits;
            rd_data[ERRCODE_FLAG_BIT] = |err_bits;
            rd_data[ERRCODE_ACTIVE_BIT] = s_reg.msg_active;
            rd_data[ERRCODE_WAIT_BIT] = s_reg.hold_full;
        end else if (rd_addr == OFS_DATA) begin
            rd_data[DATA_LINES-1:0] = s_reg.hold_data;
        end
    end

    always_comb begin
        err_lines = '0;
        err_lines[ERR_LINE_LO +: ERR_BITS] = err_bits;
    end

    // mux and enable are combinational so the host sees select changes at once
    assign host_out.data = !host_in.bus_en ? '0
        : (host_in.out_sel ? s_reg.hold_data : err_lines);
    assign host_out.oe_n = {DATA_LINES{!host_in.bus_en}};

    assign err_flag = |err_bits;
    assign msg_active = s_reg.msg_active;
    assign byte_waiting = s_reg.hold_full;
    assign irq = |(s_reg.status & s_reg.mask);
endmodule // brx_port

/* sim/brx_port_asserts.sv */
`timescale 1ns/1ns
module brx_port_asserts (
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, active low
    input wire brx_pkg::brx_host_in_t host_in, // host controls
    input wire brx_pkg::brx_host_out_t host_out, // host bus
    input wire brx_pkg::brx_rx_ev_t rx_ev, // receiver events
    input wire logic err_flag, // any error latched
    input wire logic msg_active, // message in progress
    input wire logic byte_waiting // holding full
);
    import brx_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // strobe low, then released with the select held
    sequence s_read(sel);
        !host_in.rd_n && host_in.out_sel == sel ##1 host_in.rd_n && host_in.out_sel == sel;
    endsequence
    a_oe_follow: assert property (host_out.oe_n == {DATA_LINES{~host_in.bus_en}})
        else $error("oe_n not following bus enable");
    a_idle_quiet: assert property (!host_in.bus_en |-> host_out.data == '0)
        else $error("data not quiet while bus released");
    a_mux_fixed: assert property (host_in.bus_en && !host_in.out_sel |->
        host_out.data[4] == (host_out.data[3] | host_out.data[5] | host_out.data[6])
        && host_out.data[1:0] == 2'h0 && !host_out.data[9])
        else $error("error word layout wrong");
    a_err_kills: assert property ($rose(err_flag) |-> !msg_active && !byte_waiting)
        else $error("error did not end message");
    a_active_start: assert property ($rose(msg_active) |-> $past(rx_ev.start_seq))
        else $error("message began without start");
    a_restart_err: assert property (rx_ev.start_seq && byte_waiting |=> err_flag)
        else $error("restart over unread byte not flagged");
    a_parity_err: assert property (msg_active && rx_ev.parity_err |=>
        err_flag && !msg_active) else $error("parity error not flagged");
    a_err_read_clr: assert property (s_read(1'b0) ##0 (!msg_active && !rx_ev.start_seq)
        |=> !err_flag) else $error("error read did not clear flag");
    a_start_clr: assert property (rx_ev.start_seq && !byte_waiting && !msg_active
        |=> !err_flag) else $error("start did not clear errors");
    a_byte_gap: assert property (s_read(1'b1) ##0 byte_waiting |=> !byte_waiting)
        else $error("byte waiting not dropped after read");
endmodule // brx_port_asserts
bind brx_port brx_port_asserts u_brx_port_asserts (.hclk(hclk), .hresetn(hresetn),
    .host_in(host_in), .host_out(host_out), .rx_ev(rx_ev), .err_flag(err_flag),
    .msg_active(msg_active), .byte_waiting(byte_waiting));

/* sim/brx_host_model.sv */
`timescale 1ns/1ns
module brx_host_model (
    input wire logic hclk, // clock
    output brx_pkg::brx_host_in_t host_in, // strobe and selects
    input wire brx_pkg::brx_host_out_t host_out // parallel bus
);
    import brx_pkg::*;
    initial host_in = '{out_sel: 1'b1, bus_en: 1'b0, rd_n: 1'b1};
    // select stays put past the release edge, where the device samples it
    task automatic rd(input logic sel, output logic [DATA_LINES-1:0] d);
        @(posedge hclk);
        host_in <= '{out_sel: sel, bus_en: 1'b1, rd_n: 1'b0};
        @(posedge hclk);
        d = host_out.data;
        host_in.rd_n <= 1'b1;
        @(posedge hclk);
        host_in.bus_en <= 1'b0;
    endtask
endmodule // brx_host_model

/* sim/brx_port_tb_top.sv */
`timescale 1ns/1ns
module brx_port_tb_top;
    import brx_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, err_flag, msg_active, byte_waiting, irq;
    logic [31:0] hrdata, rv;
    logic [9:0] d;
    brx_host_in_t host_in;
    brx_host_out_t host_out;
    brx_rx_ev_t ev = '0;
    int err_total = 0;
    int n_tests = 0;
    // error cases: event flags, bytes sent first, expected error word
    logic [6:0] ef [7] = '{7'h08, 7'h10, 7'h04, 7'h02, 7'h00, 7'h40, 7'h0C};
    int nb [7] = '{0, 0, 0, 0, 3, 1, 0};
    logic [9:0] ex [7] = '{10'h018, 10'h030, 10'h050, 10'h100, 10'h004, 10'h080, 10'h058};
    always #2 hclk = ~hclk;
    brx_port u_brx_port (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .host_in(host_in),
        .host_out(host_out), .rx_ev(ev), .err_flag(err_flag), .msg_active(msg_active),
        .byte_waiting(byte_waiting), .irq(irq));
    brx_host_model u_brx_host_model (.hclk(hclk), .host_in(host_in), .host_out(host_out));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic rdy_wait;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 64);
        if (hreadyout !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] q);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        rdy_wait();
        htrans <= 2'h0;
        hwdata <= wd;
        rdy_wait();
        q = hrdata;
    endtask
    task automatic pulse(input logic [6:0] f, input logic [9:0] b);
        @(posedge hclk);
        ev <= brx_rx_ev_t'({f, b});
        @(posedge hclk);
        ev <= '0;
    endtask
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("oe_n idle", 32'h3FF, 32'(host_out.oe_n));
        ahb(1'b0, OFS_CTRL, 32'h0, rv);
        chk("ctrl", 32'h1, rv);
        ahb(1'b0, OFS_MASK, 32'h0, rv);
        chk("mask", 32'h0, rv);
        ahb(1'b0, 8'h1C, 32'h0, rv);
        chk("unmapped", 32'h0, rv);
        chk("hresp", 32'h0, 32'(hresp));
        $display("test reset done");
        // second byte must wait until the first is read
        pulse(7'h40, 10'h0);
        pulse(7'h01, 10'h2A5);
        pulse(7'h01, 10'h15A);
        u_brx_host_model.rd(1'b1, d);
        chk("byte0", 32'h2A5, 32'(d));
        repeat (2) @(posedge hclk);
        chk("waiting", 32'h1, 32'(byte_waiting));
        u_brx_host_model.rd(1'b1, d);
        chk("byte1", 32'h15A, 32'(d));
        pulse(7'h20, 10'h0);
        @(posedge hclk);
        chk("active", 32'h0, 32'(msg_active));
        ahb(1'b0, OFS_DATA, 32'h0, rv);
        chk("data reg", 32'h15A, rv);
        $display("test data done");
        for (int k = 0; k < 7; k++) begin
            pulse(7'h40, 10'h0);
            repeat (nb[k]) pulse(7'h01, 10'h0F0);
            if (ef[k] != 7'h00)
                pulse(ef[k], 10'h0);
            @(posedge hclk);
            chk("err_flag", 32'h1, 32'(err_flag));
            ahb(1'b0, OFS_ERRCODE, 32'h0, rv);
            chk("err reg", 32'h100 | 32'(ex[k] >> ERR_LINE_LO), rv);
            u_brx_host_model.rd(1'b0, d);
            chk("err code", 32'(ex[k]), 32'(d));
            @(posedge hclk);
            chk("err cleared", 32'h0, 32'(err_flag));
        end
        $display("test errors done");
        ahb(1'b1, OFS_MASK, 32'h1, rv);
        @(posedge hclk);
        chk("irq on", 32'h1, 32'(irq));
        ahb(1'b0, OFS_STATUS, 32'h0, rv);
        chk("status", 32'h7, rv);
        ahb(1'b1, OFS_STATUS, 32'h7, rv);
        @(posedge hclk);
        chk("irq clr", 32'h0, 32'(irq));
        pulse(7'h40, 10'h0);
        pulse(7'h08, 10'h0);
        @(posedge hclk);
        chk("irq err", 32'h1, 32'(irq));
        ahb(1'b1, OFS_MASK, 32'h0, rv);
        @(posedge hclk);
        chk("irq masked", 32'h0, 32'(irq));
        u_brx_host_model.rd(1'b0, d);
        $display("test irq done");
        // receiver off: a start must not open a message
        ahb(1'b1, OFS_CTRL, 32'h0, rv);
        pulse(7'h40, 10'h0);
        @(posedge hclk);
        chk("start off", 32'h0, 32'(msg_active));
        ahb(1'b1, OFS_CTRL, 32'h1, rv);
        pulse(7'h40, 10'h0);
        @(posedge hclk);
        chk("start on", 32'h1, 32'(msg_active));
        $display("test enable done");
        complete_run();
    end
endmodule // brx_port_tb_top
